/* core/tws_consts.vh */
// constants for the three-wire serial pin and shift block
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// system clock period, ns
`define TWS_CLK_NS        25
// half period of the internally generated shift clock, ns
`define TWS_SCK_HALF_NS   1000
// half period in system clock cycles, rounded up
`define TWS_SCK_HALF_CYC  ((`TWS_SCK_HALF_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
// divider counter width
`define TWS_DIV_W         6
// shift register width and bit count per transfer
`define TWS_PSR_W         8
`define TWS_BIT_CNT       4'h8
`define TWS_CNT_W         4
// value given to the shift register at power-on; content counts as undefined
`define TWS_PSR_POR       8'h00
// idle level of the internal shift clock
`define TWS_SCK_IDLE      1'b1

`endif

/* core/tws_sync.v */
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module tws_sync (
	clk_sys,
	sys_rst,
	asyncIn,
	syncOut
);
	input  wire clk_sys;
	input  wire sys_rst;
	input  wire asyncIn;
	output wire syncOut;

	reg meta_r;
	reg sync_r;

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			// lines rest high, so no false edge follows reset
			meta_r <= 1'b1;
			sync_r <= 1'b1;
		end else begin
			meta_r <= asyncIn;
			sync_r <= meta_r;
		end
	end

	assign syncOut = sync_r;
endmodule // tws_sync

/* core/tws_clkgen.v */
// divider giving one-cycle half-period ticks for the internal shift clock
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_clkgen (
	clk_sys,
	sys_rst,
	run,
	tick
);
	input  wire clk_sys;
	input  wire sys_rst;
	input  wire run;
	output wire tick;

	localparam integer          HALF_NUM  = `TWS_SCK_HALF_CYC - 1;
	localparam [`TWS_DIV_W-1:0] HALF_LAST = HALF_NUM[`TWS_DIV_W-1:0];

	reg [`TWS_DIV_W-1:0] divCnt_r;

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			divCnt_r <= {`TWS_DIV_W{1'b0}};
		end else if (!run || divCnt_r == HALF_LAST) begin
			divCnt_r <= {`TWS_DIV_W{1'b0}};
		end else begin
			divCnt_r <= divCnt_r + 1'b1;
		end
	end

	assign tick = run && (divCnt_r == HALF_LAST);
endmodule // tws_clkgen

/* core/tws_serial.v */
// three-wire serial interface: pin states, shift register, halt and reset behaviour
// What this block does
// - external clock: await pin edges, output on falling, capture on rising
// - internal clock: drive generated shift clock on pin, shift on those edges
// - power-on reset makes all serial pins floating general-purpose inputs
// - power-on reset leaves shift register content undefined
// - clock-stop reset floats pins, shift register keeps its value
// - chip-enable reset floats pins, shift register keeps its value
// - during halt every serial pin keeps its configuration; data out still changes on shift edges that reach the pin
// - internal clock: halt stops shift clock generation at once
// - internal clock in halt: externally forced edges still shift data
// - external clock: halt does not interrupt the transfer
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_serial (
	clk_sys,
	sys_rst,
	clkStopRst,
	ceRst,
	haltActive,
	cfgWrite,
	cfgSerialEn,
	cfgExtClk,
	cfgTxEn,
	startReq,
	presetWrite,
	presetData,
	presetValue,
	waitReleaseFlag,
	xferDoneIrq,
	serialClockIn,
	serialClockOut,
	serialClockOe,
	serialOut,
	serialOutOe,
	serialIn
);
	input  wire                  clk_sys;
	input  wire                  sys_rst;
	input  wire                  clkStopRst;
	input  wire                  ceRst;
	input  wire                  haltActive;
	input  wire                  cfgWrite;
	input  wire                  cfgSerialEn;
	input  wire                  cfgExtClk;
	input  wire                  cfgTxEn;
	input  wire                  startReq;
	input  wire                  presetWrite;
	input  wire [`TWS_PSR_W-1:0] presetData;
	output wire [`TWS_PSR_W-1:0] presetValue;
	output wire                  waitReleaseFlag;
	output wire                  xferDoneIrq;
	input  wire                  serialClockIn;
	output wire                  serialClockOut;
	output wire                  serialClockOe;
	output wire                  serialOut;
	output wire                  serialOutOe;
	input  wire                  serialIn;

	// ==========================================================
	// state and configuration
	// ==========================================================
	localparam [1:0] ST_WAIT  = 2'h0;
	localparam [1:0] ST_SHIFT = 2'h1;
	localparam [1:0] ST_DONE  = 2'h2;

	reg [1:0]            state_r;
	reg [1:0]            state_nxt;
	reg                  serialEn_r;
	reg                  extClk_r;
	reg                  txEn_r;
	reg [`TWS_PSR_W-1:0] psr_r;
	reg [`TWS_PSR_W-1:0] psr_nxt;
	reg [`TWS_CNT_W-1:0] bitCnt_r;
	reg [`TWS_CNT_W-1:0] bitCnt_nxt;
	reg                  sckOut_r;
	reg                  soOut_r;
	reg                  sckPrev_r;
	reg                  done_r;
	reg                  clkOe_r;
	reg                  soOe_r;

	wire softRst = clkStopRst | ceRst;
	wire active  = (state_r == ST_SHIFT);
	wire cfgAccept = cfgWrite && !active && !haltActive;
	wire sckSync;
	wire siSync;
	wire genTick;
	wire sckRise;
	wire sckFall;

	// ==========================================================
	// pin input synchronisers
	// ==========================================================
	tws_sync uSckSync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.asyncIn (serialClockIn),
		.syncOut (sckSync)
	);

	tws_sync uSiSync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.asyncIn (serialIn),
		.syncOut (siSync)
	);

	// ==========================================================
	// internal shift clock generator
	// ==========================================================
	// generator halts with the processor; transfer must be over by then
	wire genRun = active && serialEn_r && !extClk_r && !haltActive;

	tws_clkgen uClkGen (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.run     (genRun),
		.tick    (genTick)
	);

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sckOut_r <= `TWS_SCK_IDLE;
		end else if (softRst) begin
			sckOut_r <= `TWS_SCK_IDLE;
		end else if (genTick) begin
			sckOut_r <= ~sckOut_r;
		end else if (!active && !haltActive) begin
			// wait: clock pin rests high; in halt it holds its level
			sckOut_r <= `TWS_SCK_IDLE;
		end
	end

	// ==========================================================
	// edge detection on the clock pin level
	// ==========================================================
	// the pin level is used in both modes, so forced edges also shift
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sckPrev_r <= `TWS_SCK_IDLE;
		end else begin
			sckPrev_r <= sckSync;
		end
	end

	// ==========================================================
	// edge decode shared by both directions
	// ==========================================================
	function edgeSeen;
		input now;
		input prev;
		input rising;
		begin
			edgeSeen = rising ? (now && !prev) : (!now && prev);
		end
	endfunction

	assign sckRise = edgeSeen(sckSync, sckPrev_r, 1'b1);
	assign sckFall = edgeSeen(sckSync, sckPrev_r, 1'b0);

	// ==========================================================
	// configuration latch, cleared by every reset
	// ==========================================================
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			serialEn_r <= 1'b0;
			extClk_r   <= 1'b1;
			txEn_r     <= 1'b0;
		end else if (softRst) begin
			serialEn_r <= 1'b0;
			extClk_r   <= 1'b1;
			txEn_r     <= 1'b0;
		end else if (cfgAccept) begin
			serialEn_r <= cfgSerialEn;
			extClk_r   <= cfgExtClk;
			txEn_r     <= cfgTxEn;
		end
	end

	// ==========================================================
	// pin output enables, held through halt
	// ==========================================================
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			clkOe_r <= 1'b0;
			soOe_r  <= 1'b0;
		end else if (softRst) begin
			clkOe_r <= 1'b0;
			soOe_r  <= 1'b0;
		end else if (cfgAccept) begin
			clkOe_r <= cfgSerialEn && !cfgExtClk;
			soOe_r  <= cfgSerialEn && cfgTxEn;
		end
	end

	// ==========================================================
	// transfer sequencer
	// ==========================================================
	always @* begin
		state_nxt  = state_r;
		bitCnt_nxt = bitCnt_r;
		case (state_r)
			ST_WAIT: begin
				bitCnt_nxt = {`TWS_CNT_W{1'b0}};
				if (startReq && serialEn_r) begin
					state_nxt = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				// external mode keeps counting through halt
				if (sckRise) begin
					bitCnt_nxt = bitCnt_r + 1'b1;
					if (bitCnt_r == `TWS_BIT_CNT - 1'b1) begin
						state_nxt = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				state_nxt = ST_WAIT;
			end
			default: begin
				state_nxt = ST_WAIT;
			end
		endcase
	end

	// ==========================================================
	// state registers
	// ==========================================================
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_r  <= ST_WAIT;
			bitCnt_r <= {`TWS_CNT_W{1'b0}};
		end else if (softRst) begin
			state_r  <= ST_WAIT;
			bitCnt_r <= {`TWS_CNT_W{1'b0}};
		end else begin
			state_r  <= state_nxt;
			bitCnt_r <= bitCnt_nxt;
		end
	end

	// ==========================================================
	// completion request, one cycle as shifting ends
	// ==========================================================
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			done_r <= 1'b0;
		end else if (softRst) begin
			done_r <= 1'b0;
		end else begin
			done_r <= (state_nxt == ST_DONE);
		end
	end

	// ==========================================================
	// presettable shift register and serial output
	// ==========================================================
	always @* begin
		psr_nxt = psr_r;
		if (softRst) begin
			psr_nxt = psr_r;
		end else if (active && sckRise) begin
			psr_nxt = {psr_r[`TWS_PSR_W-2:0], siSync};
		end else if (presetWrite && !active) begin
			psr_nxt = presetData;
		end
	end

	// only power-on touches the register; soft resets keep it
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			psr_r <= `TWS_PSR_POR;
		end else begin
			psr_r <= psr_nxt;
		end
	end

	// ==========================================================
	// serial data out
	// ==========================================================
	// serial out holds its last level outside transfers
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			soOut_r <= 1'b0;
		end else if (active && txEn_r && sckFall && !softRst) begin
			soOut_r <= psr_r[`TWS_PSR_W-1];
		end
	end

	// ==========================================================
	// pin drivers
	// ==========================================================
	assign serialClockOut  = sckOut_r;
	assign serialClockOe   = clkOe_r;
	assign serialOut       = soOut_r;
	assign serialOutOe     = soOe_r;
	assign presetValue     = psr_r;
	assign waitReleaseFlag = active;
	assign xferDoneIrq     = done_r;
endmodule // tws_serial

/* dv/tws_serial_monitor.sv */
// assertion checker for the serial pin block
`timescale 1ns/1ps
module tws_serial_monitor (
	input wire       clk_sys,
	input wire       sys_rst,
	input wire       clkStopRst,
	input wire       ceRst,
	input wire       haltActive,
	input wire       serialClockIn,
	input wire       serialClockOut,
	input wire       serialClockOe,
	input wire       serialOut,
	input wire       serialOutOe,
	input wire [7:0] presetValue,
	input wire       waitReleaseFlag,
	input wire       xferDoneIrq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_por; $fell(sys_rst) |-> !serialClockOe && !serialOutOe; endproperty
	a_por: assert property (p_por) else $error("pins driven after reset");
	property p_stop;
		clkStopRst |=> !serialClockOe && !serialOutOe && presetValue == $past(presetValue);
	endproperty
	a_stop: assert property (p_stop) else $error("clock-stop reset state");
	property p_ce;
		ceRst |=> !serialClockOe && !serialOutOe && presetValue == $past(presetValue);
	endproperty
	a_ce: assert property (p_ce) else $error("chip-enable reset state");
	property p_halt; haltActive |=> $stable(serialClockOe) && $stable(serialOutOe); endproperty
	a_halt: assert property (p_halt) else $error("pins changed in halt");
	property p_hclk; haltActive |=> $stable(serialClockOut); endproperty
	a_hclk: assert property (p_hclk) else $error("clock ran in halt");
	property p_out; serialOut != $past(serialOut) && waitReleaseFlag |-> !$past(serialClockIn, 2);
	endproperty
	a_out: assert property (p_out) else $error("data out off falling edge");
	property p_done;
		xferDoneIrq |-> ($past(waitReleaseFlag) && !waitReleaseFlag) ##1 !xferDoneIrq;
	endproperty
	a_done: assert property (p_done) else $error("bad completion pulse");
	property p_len; $rose(waitReleaseFlag) |-> ##[50:720] xferDoneIrq; endproperty
	a_len: assert property (p_len) else $error("transfer length");
	c_done: cover property (xferDoneIrq);
	c_halt: cover property (haltActive && xferDoneIrq);
	c_stop: cover property (clkStopRst);
endmodule // tws_serial_monitor
bind tws_serial tws_serial_monitor mon_u (
	.clk_sys         (clk_sys),
	.sys_rst         (sys_rst),
	.clkStopRst      (clkStopRst),
	.ceRst           (ceRst),
	.haltActive      (haltActive),
	.serialClockIn   (serialClockIn),
	.serialClockOut  (serialClockOut),
	.serialClockOe   (serialClockOe),
	.serialOut       (serialOut),
	.serialOutOe     (serialOutOe),
	.presetValue     (presetValue),
	.waitReleaseFlag (waitReleaseFlag),
	.xferDoneIrq     (xferDoneIrq)
);

/* dv/tws_peer.sv */
// behavioural far-side serial peer, master or slave
`timescale 1ns/1ps
module tws_peer (
	input  wire       clkWire,
	input  wire       dataIn,
	input  wire       go,
	input  wire       master,
	input  wire [7:0] txByte,
	output reg        extClk,
	output reg        dataOut,
	output reg  [7:0] rxByte
);
	reg [7:0] sh;
	integer   i;
	initial begin
		extClk = 1'h1;
		dataOut = 1'h0;
		rxByte = 8'h00;
	end
	// clock stands high outside frames
	always @(posedge go) begin
		sh = txByte;
		if (master) begin
			for (i = 0; i < 8; i = i + 1) begin
				#100 extClk = 1'h0;
				#100 extClk = 1'h1;
			end
		end
	end
	always @(negedge clkWire) begin
		dataOut = sh[7];
		sh = {sh[6:0], 1'h0};
	end
	always @(posedge clkWire) rxByte = {rxByte[6:0], dataIn};
endmodule // tws_peer

/* dv/tws_serial_bench.sv */
// self-checking bench for the serial pin block
`timescale 1ns/1ps
module tws_serial_bench;
	reg        clk_sys = 1'h0, sys_rst = 1'h1, clkStopRst = 1'h0, ceRst = 1'h0;
	reg        haltActive = 1'h0, cfgWrite = 1'h0, cfgSerialEn = 1'h0, cfgExtClk = 1'h0;
	reg        cfgTxEn = 1'h0, startReq = 1'h0, presetWrite = 1'h0, peerGo = 1'h0;
	reg        master = 1'h0, forceClk = 1'h0;
	reg  [7:0] presetData = 8'h00, txByte = 8'h00;
	wire [7:0] presetValue, rxByte;
	wire       waitReleaseFlag, xferDoneIrq, serialClockOut, serialClockOe, serialOut;
	wire       serialOutOe, extClk, serialIn;
	integer    n_errors = 0, checks_done = 0, cyc = 0;
	wire       serialClockIn = (serialClockOe && !forceClk) ? serialClockOut : extClk;
	// undriven data line shows the inverse level
	wire       soWire = serialOutOe ? serialOut : ~serialOut;
	always #12.5 clk_sys = ~clk_sys;
	tws_serial dut_u (
		.clk_sys         (clk_sys),
		.sys_rst         (sys_rst),
		.clkStopRst      (clkStopRst),
		.ceRst           (ceRst),
		.haltActive      (haltActive),
		.cfgWrite        (cfgWrite),
		.cfgSerialEn     (cfgSerialEn),
		.cfgExtClk       (cfgExtClk),
		.cfgTxEn         (cfgTxEn),
		.startReq        (startReq),
		.presetWrite     (presetWrite),
		.presetData      (presetData),
		.presetValue     (presetValue),
		.waitReleaseFlag (waitReleaseFlag),
		.xferDoneIrq     (xferDoneIrq),
		.serialClockIn   (serialClockIn),
		.serialClockOut  (serialClockOut),
		.serialClockOe   (serialClockOe),
		.serialOut       (serialOut),
		.serialOutOe     (serialOutOe),
		.serialIn        (serialIn)
	);
	tws_peer peer_u (.clkWire(serialClockIn), .dataIn(soWire), .go(peerGo), .master(master),
		.txByte(txByte), .extClk(extClk), .dataOut(serialIn), .rxByte(rxByte));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("wrong value at %0t: %h, expected %h", $time, got, exp);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d errors %0d", checks_done, n_errors);
			if (n_errors == 0 && checks_done > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task cfg(input e, input t);
		begin
			cfgSerialEn = 1'h1;
			cfgExtClk = e;
			cfgTxEn = t;
			cfgWrite = 1'h1;
			@(negedge clk_sys) cfgWrite = 1'h0;
		end
	endtask
	// one byte each way; optional halt and forced clock after start
	task xfer(input e, input h, input f, input [7:0] pv, input [7:0] pd);
		integer n;
		begin
			cfg(e, 1'h1);
			presetData = pv;
			presetWrite = 1'h1;
			@(negedge clk_sys) presetWrite = 1'h0;
			txByte = pd;
			master = e | f;
			startReq = 1'h1;
			peerGo = 1'h1;
			@(negedge clk_sys) startReq = 1'h0;
			peerGo = 1'h0;
			haltActive = h;
			forceClk = f;
			chk({7'h00, waitReleaseFlag}, 8'h01);
			n = 0;
			while (!xferDoneIrq && n < 900) begin
				@(negedge clk_sys) n = n + 1;
			end
			chk({7'h00, xferDoneIrq}, 8'h01);
			chk(presetValue, pd);
			chk(rxByte, pv);
			@(negedge clk_sys) chk({7'h00, waitReleaseFlag}, 8'h00);
			haltActive = 1'h0;
			forceClk = 1'h0;
			$display("transfer test done");
		end
	endtask
	task t_soft(input k);
		begin
			cfg(k, 1'h1);
			chk({6'h00, serialClockOe, serialOutOe}, {6'h00, !k, 1'h1});
			clkStopRst = !k;
			ceRst = k;
			@(negedge clk_sys) clkStopRst = 1'h0;
			ceRst = 1'h0;
			chk({6'h00, serialClockOe, serialOutOe}, 8'h00);
			chk(presetValue, 8'hF0);
			$display("soft reset test done");
		end
	endtask
	// master halt entered only after its transfer is over; data pin left off
	task t_halt;
		begin
			cfg(1'h0, 1'h0);
			haltActive = 1'h1;
			repeat (60) @(negedge clk_sys);
			chk({4'h0, serialClockOut, serialClockOe, serialOutOe, waitReleaseFlag}, 8'h0C);
			haltActive = 1'h0;
			$display("halt test done");
		end
	endtask
	initial begin
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'h0;
		@(negedge clk_sys) chk({6'h00, serialClockOe, serialOutOe}, 8'h00);
		xfer(1'h1, 1'h0, 1'h0, 8'hA5, 8'h3C);
		xfer(1'h0, 1'h0, 1'h0, 8'hC3, 8'h5A);
		xfer(1'h1, 1'h1, 1'h0, 8'h96, 8'h69);
		xfer(1'h0, 1'h1, 1'h1, 8'h0F, 8'hF0);
		t_halt;
		t_soft(1'h0);
		t_soft(1'h1);
		end_of_test;
	end
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_errors = n_errors + 1;
			end_of_test;
		end
	end
endmodule // tws_serial_bench
